// ==== verilog/mcl_guard.sv ====
// Purpose: current limit, boost, thermal derate, stall guard, compensation
// Assumes: i_motor_cur_a and i_overtemp come from outside and are synced
// Notes: stall fault clears only by i_reset_n (power cycle)
`timescale 1ns/1ps
`default_nettype none
module mcl_guard #(
    parameter logic [7:0] RATING_A = 8'h28,
    parameter int TICK_CYCLES = mcl_pkg::TICK_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic [7:0] i_motor_cur_a,
    input wire logic i_overtemp,
    input wire logic i_brake_engage,
    input wire logic i_brake_release,
    output logic [7:0] o_cur_cmd_a,
    output logic [17:0] o_comp_mv,
    output logic o_drive_en,
    output logic o_estop,
    output logic [3:0] o_fault_code,
    output logic o_irq
);
    // pin synchronisers
    logic [7:0] cur_s1_ff, cur_ff;
    logic ot_s1_ff, ot_ff, be_s1_ff, be_ff, br_s1_ff, br_ff;
    logic be_d_ff, br_d_ff;
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            cur_s1_ff <= 8'h00;
            cur_ff <= 8'h00;
            {ot_s1_ff, ot_ff, be_s1_ff, be_ff} <= 4'h0;
            {br_s1_ff, br_ff, be_d_ff, br_d_ff} <= 4'h0;
        end
        else if (i_clk_en)
        begin
            cur_s1_ff <= i_motor_cur_a;
            cur_ff <= cur_s1_ff;
            ot_s1_ff <= i_overtemp;
            ot_ff <= ot_s1_ff;
            be_s1_ff <= i_brake_engage;
            be_ff <= be_s1_ff;
            br_s1_ff <= i_brake_release;
            br_ff <= br_s1_ff;
            be_d_ff <= be_ff;
            br_d_ff <= br_ff;
        end
    end
    wire logic brake_on_p = be_ff & ~be_d_ff;
    wire logic brake_off_p = br_ff & ~br_d_ff;

    // configuration registers
    logic [9:0] comp_ff, maxcomp_ff;
    logic [6:0] damp_ff, remem_ff;
    logic [7:0] ilim_ff, boost_a_ff;
    logic [5:0] boost_s_ff, stall_s_ff;
    localparam int NEVW = mcl_pkg::NEV;
    logic [NEVW-1:0] irq_st_ff, irq_en_ff;

    // AHB-Lite address phase capture; zero wait states
    logic wr_ff, rd_ff;
    logic [7:0] addr_ff;
    wire logic take = i_hsel & i_hready & i_htrans[1];
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            addr_ff <= 8'h00;
        end
        else if (i_clk_en)
        begin
            wr_ff <= take & i_hwrite;
            rd_ff <= take & ~i_hwrite;
            if (take)
                addr_ff <= i_haddr[7:0];
        end
    end
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;

    // clamp percentages and times on write
    function automatic logic [6:0] clp(input logic [31:0] v);
        clp = (v > 32'(mcl_pkg::PCT_MAX)) ? mcl_pkg::PCT_MAX : v[6:0];
    endfunction
    function automatic logic [5:0] clt(input logic [31:0] v);
        clt = (v > 32'(mcl_pkg::TIME_MAX_S)) ? mcl_pkg::TIME_MAX_S : v[5:0];
    endfunction
    function automatic logic [9:0] clr(input logic [31:0] v);
        clr = (v > 32'(mcl_pkg::COMP_MAX_MOHM)) ?
            mcl_pkg::COMP_MAX_MOHM : v[9:0];
    endfunction

    // register writes
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            comp_ff <= mcl_pkg::RST_COMP;
            maxcomp_ff <= mcl_pkg::RST_MAXCOMP;
            damp_ff <= mcl_pkg::RST_DAMP;
            remem_ff <= mcl_pkg::RST_REMEM;
            ilim_ff <= mcl_pkg::RST_ILIM;
            boost_a_ff <= mcl_pkg::RST_BOOST_A;
            boost_s_ff <= mcl_pkg::RST_BOOST_S;
            stall_s_ff <= mcl_pkg::RST_STALL_S;
            irq_en_ff <= '0;
        end
        else if (i_clk_en && wr_ff)
        begin
            unique case (addr_ff)
                mcl_pkg::A_COMP: comp_ff <= clr(i_hwdata);
                mcl_pkg::A_MAXCOMP: maxcomp_ff <= clr(i_hwdata);
                mcl_pkg::A_DAMP: damp_ff <= clp(i_hwdata);
                mcl_pkg::A_REMEM: remem_ff <= clp(i_hwdata);
                mcl_pkg::A_ILIM: ilim_ff <= i_hwdata[7:0];
                mcl_pkg::A_BOOST:
                begin
                    boost_a_ff <= i_hwdata[7:0];
                    boost_s_ff <= clt({24'h000000, i_hwdata[15:8]});
                end
                mcl_pkg::A_STALL: stall_s_ff <= clt(i_hwdata);
                mcl_pkg::A_IRQ_EN: irq_en_ff <= i_hwdata[NEVW-1:0];
                default: ;
            endcase
        end
    end

    // 100 ms time base
    logic [23:0] tick_cnt_ff;
    wire logic tick = (tick_cnt_ff == 24'(TICK_CYCLES - 1));
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
            tick_cnt_ff <= 24'h000000;
        else if (i_clk_en)
            tick_cnt_ff <= tick ? 24'h000000 : tick_cnt_ff + 24'h000001;
    end

    // current limit: rating clamp, thermal derate
    logic [7:0] lim_a, lim_hot, max_a;
    logic boost_ok_ff;
    always_comb
    begin
        lim_a = (ilim_ff > RATING_A) ? RATING_A : ilim_ff;
        lim_hot = (lim_a > mcl_pkg::THERM_DERATE_A) ?
            lim_a - mcl_pkg::THERM_DERATE_A : 8'h00;
        if (ot_ff)
            lim_a = lim_hot;
        max_a = lim_a;
        if (boost_ok_ff && !ot_ff)
            max_a = (9'(lim_a) + 9'(boost_a_ff) > 9'h0FF) ? 8'hFF :
                lim_a + boost_a_ff;
    end
    wire logic above = cur_ff > lim_a;
    wire logic at_max = cur_ff >= max_a;

    // boost budget: time above limit, re-arm after twice that below
    logic [9:0] above_t_ff, below_t_ff;
    logic boost_exp_p;
    wire logic [9:0] boost_ticks =
        10'(boost_s_ff) * 10'(mcl_pkg::TICKS_PER_S);
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            above_t_ff <= 10'h000;
            below_t_ff <= 10'h000;
            boost_ok_ff <= 1'b1;
        end
        else if (i_clk_en && tick)
        begin
            if (above)
            begin
                below_t_ff <= 10'h000;
                if (above_t_ff != 10'h3FF)
                    above_t_ff <= above_t_ff + 10'h001;
                if (boost_ok_ff && above_t_ff + 10'h001 >= boost_ticks)
                    boost_ok_ff <= 1'b0;
            end
            else if (above_t_ff != 10'h000)
            begin
                below_t_ff <= below_t_ff + 10'h001;
                if ({1'b0, below_t_ff} + 11'h001 >= {above_t_ff, 1'b0})
                begin
                    boost_ok_ff <= 1'b1;
                    above_t_ff <= 10'h000;
                    below_t_ff <= 10'h000;
                end
            end
        end
    end
    assign boost_exp_p = i_clk_en & tick & above & boost_ok_ff &
        (above_t_ff + 10'h001 >= boost_ticks);

    // stall timer and latched fault
    logic [9:0] stall_t_ff;
    logic fault_ff;
    wire logic [9:0] stall_ticks =
        10'(stall_s_ff) * 10'(mcl_pkg::TICKS_PER_S);
    wire logic stall_hit = (stall_s_ff != 6'h00) &&
        (stall_t_ff + 10'h001 >= stall_ticks);
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            stall_t_ff <= 10'h000;
            fault_ff <= 1'b0;
        end
        else if (i_clk_en)
        begin
            if (!at_max || stall_s_ff == 6'h00)
                stall_t_ff <= 10'h000;
            else if (tick && !fault_ff)
            begin
                stall_t_ff <= stall_t_ff + 10'h001;
                if (stall_hit)
                    fault_ff <= 1'b1;
            end
        end
    end
    wire logic stall_p = i_clk_en & tick & at_max & ~fault_ff & stall_hit;

    // remembered holding current and start compensation
    logic [7:0] hold_a_ff;
    logic parked_ff, seed_ff;
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            hold_a_ff <= 8'h00;
            parked_ff <= 1'b0;
            seed_ff <= 1'b0;
        end
        else if (i_clk_en)
        begin
            if (brake_on_p)
            begin
                hold_a_ff <= cur_ff;
                parked_ff <= 1'b1;
            end
            if (brake_off_p)
            begin
                seed_ff <= parked_ff;
                parked_ff <= 1'b0;
            end
            else if (seed_ff && cur_ff > hold_a_ff)
                seed_ff <= 1'b0; // live current takes over
        end
    end

    // compensation voltage: I * R * (100 - damp) / 100, or held I * R * remem / 100 while seeded
    logic [9:0] r_eff;
    logic [7:0] i_use;
    logic [6:0] pct;
    logic [24:0] prod;
    logic [17:0] comp_mv_ff;
    always_comb
    begin
        r_eff = (comp_ff > maxcomp_ff) ? maxcomp_ff : comp_ff;
        if (seed_ff)
        begin
            i_use = hold_a_ff;
            pct = remem_ff;
        end
        else
        begin
            i_use = cur_ff;
            pct = mcl_pkg::PCT_FULL - damp_ff;
        end
        prod = 25'(i_use) * 25'(r_eff) * 25'(pct);
    end
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
            comp_mv_ff <= 18'h00000;
        else if (i_clk_en)
            comp_mv_ff <= fault_ff ? 18'h00000 :
                18'(prod / 25'(mcl_pkg::PCT_FULL));
    end

    // outputs
    logic [7:0] cur_cmd_ff;
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
            cur_cmd_ff <= 8'h00;
        else if (i_clk_en)
            cur_cmd_ff <= fault_ff ? 8'h00 : max_a;
    end
    assign o_cur_cmd_a = cur_cmd_ff;
    assign o_comp_mv = comp_mv_ff;
    assign o_drive_en = ~fault_ff;
    assign o_estop = fault_ff;
    assign o_fault_code = fault_ff ? mcl_pkg::FAULT_STALL : 4'h0;

    // sticky interrupt status; set wins over clear
    // events: overtemp rising edge, boost expiry, stall trip
    // only the settled overtemp flop feeds the edge detector
    logic ot_d_ff;
    wire logic [NEVW-1:0] evs = {ot_ff & ~ot_d_ff, boost_exp_p, stall_p};
    wire logic [NEVW-1:0] clr_w = (i_clk_en && wr_ff &&
        addr_ff == mcl_pkg::A_IRQ_CLR) ? i_hwdata[NEVW-1:0] : '0;
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            irq_st_ff <= '0;
            ot_d_ff <= 1'b0;
        end
        else if (i_clk_en)
        begin
            ot_d_ff <= ot_ff;
            irq_st_ff <= (irq_st_ff & ~clr_w) | evs;
        end
    end
    assign o_irq = |(irq_st_ff & irq_en_ff);

    // read mux
    always_comb
    begin
        o_hrdata = 32'h00000000;
        if (rd_ff)
        begin
            unique case (addr_ff)
                mcl_pkg::A_COMP: o_hrdata = {22'h0, comp_ff};
                mcl_pkg::A_MAXCOMP: o_hrdata = {22'h0, maxcomp_ff};
                mcl_pkg::A_DAMP: o_hrdata = {25'h0, damp_ff};
                mcl_pkg::A_REMEM: o_hrdata = {25'h0, remem_ff};
                mcl_pkg::A_ILIM: o_hrdata = {24'h0, ilim_ff};
                mcl_pkg::A_BOOST: o_hrdata = {18'h0, boost_s_ff, boost_a_ff};
                mcl_pkg::A_STALL: o_hrdata = {26'h0, stall_s_ff};
                mcl_pkg::A_STATUS: o_hrdata = {16'h0, hold_a_ff, 2'h0,
                    seed_ff, parked_ff, ot_ff, boost_ok_ff, fault_ff, 1'b0};
                mcl_pkg::A_IRQ_ST: o_hrdata = {29'h0, irq_st_ff};
                mcl_pkg::A_IRQ_EN: o_hrdata = {29'h0, irq_en_ff};
                mcl_pkg::A_OUT: o_hrdata = {6'h0, comp_mv_ff, max_a};
                default: o_hrdata = 32'h00000000;
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== verilog/mcl_pkg.sv ====
// Purpose: constants for the motor current limit and stall guard
// Assumes: 10 MHz system clock, AHB-Lite register access
// Notes: currents in amperes, resistances in milliohms, times in seconds
package mcl_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_MS = 100;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam logic [9:0] COMP_MAX_MOHM = 10'h3FC; // 1020
    localparam logic [9:0] RST_MAXCOMP = 10'h3E8; // 1000
    localparam logic [9:0] RST_COMP = 10'h064; // 100
    localparam logic [6:0] PCT_MAX = 7'h3C; // 60
    localparam logic [6:0] RST_DAMP = 7'h32; // 50
    localparam logic [6:0] RST_REMEM = 7'h32; // 50
    localparam logic [6:0] PCT_FULL = 7'h64; // 100
    localparam logic [7:0] RST_ILIM = 8'h28; // 40 A
    localparam logic [7:0] RST_BOOST_A = 8'h08; // 8 A
    localparam logic [5:0] TIME_MAX_S = 6'h33; // 51 s
    localparam logic [5:0] RST_BOOST_S = 6'h04; // 4 s
    localparam logic [5:0] RST_STALL_S = 6'h19; // 25 s
    localparam logic [3:0] TICKS_PER_S = 4'hA;
    localparam logic [7:0] THERM_DERATE_A = 8'h0A; // cut when hot
    localparam logic [3:0] FAULT_STALL = 4'h4;
    // byte offsets
    localparam logic [7:0] A_COMP = 8'h00;
    localparam logic [7:0] A_MAXCOMP = 8'h04;
    localparam logic [7:0] A_DAMP = 8'h08;
    localparam logic [7:0] A_REMEM = 8'h0C;
    localparam logic [7:0] A_ILIM = 8'h10;
    localparam logic [7:0] A_BOOST = 8'h14;
    localparam logic [7:0] A_STALL = 8'h18;
    localparam logic [7:0] A_STATUS = 8'h1C;
    localparam logic [7:0] A_IRQ_ST = 8'h20;
    localparam logic [7:0] A_IRQ_CLR = 8'h24;
    localparam logic [7:0] A_IRQ_EN = 8'h28;
    localparam logic [7:0] A_OUT = 8'h2C;
    localparam int NEV = 3; // 0 stall, 1 boost expired, 2 thermal
endpackage

// ==== sim/mcl_checker.sv ====
// Purpose: port assertions for mcl_guard
// Assumes: i_clk_en held high by the bench
// Notes: bound to every mcl_guard below the module
`timescale 1ns/1ps
`default_nettype none
module mcl_checker #(
    parameter logic [7:0] RATING_A = 8'h28,
    parameter int TICK_CYCLES = 10
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [31:0] o_hrdata,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    input wire logic [7:0] i_motor_cur_a,
    input wire logic i_overtemp,
    input wire logic [7:0] o_cur_cmd_a,
    input wire logic o_drive_en,
    input wire logic o_estop,
    input wire logic [3:0] o_fault_code
);
    localparam int MIN_HI = 9 * TICK_CYCLES;
    logic [15:0] hi_cnt_ff;
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_reset_n);
    // run length of sensed current at or over the command
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n || o_cur_cmd_a == 8'h00 || i_motor_cur_a < o_cur_cmd_a)
            hi_cnt_ff <= 16'h0000;
        else if (hi_cnt_ff != 16'hFFFF)
            hi_cnt_ff <= hi_cnt_ff + 16'h0001;
    end
    // address phase of a read and a spell of overheating
    sequence s_rd(logic [7:0] a);
        i_hsel && i_htrans[1] && !i_hwrite && i_haddr[7:0] == a;
    endsequence
    sequence s_hot;
        i_overtemp [*8];
    endsequence
    property p_bus;
        o_hreadyout && (o_hresp == 1'b0);
    endproperty
    a_bus: assert property (p_bus) else $error("bus not ready or okay");
    property p_unmap;
        s_rd(8'h30) |=> o_hrdata == 32'h0000_0000;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_damp;
        s_rd(8'h08) |=> o_hrdata <= 32'h0000_003C;
    endproperty
    a_damp: assert property (p_damp) else $error("damping over 60");
    property p_mcomp;
        s_rd(8'h04) |=> o_hrdata <= 32'h0000_03FC;
    endproperty
    a_mcomp: assert property (p_mcomp) else $error("max comp over");
    property p_latch;
        o_estop |=> o_estop;
    endproperty
    a_latch: assert property (p_latch) else $error("fault released");
    property p_fault;
        o_estop |-> ##1 (!o_drive_en && o_fault_code == 4'h4 && !o_cur_cmd_a);
    endproperty
    a_fault: assert property (p_fault) else $error("fault outputs");
    property p_therm;
        s_hot |-> o_cur_cmd_a <= RATING_A - 8'h0A;
    endproperty
    a_therm: assert property (p_therm) else $error("no derate");
    property p_stall;
        $rose(o_estop) |-> hi_cnt_ff >= MIN_HI;
    endproperty
    a_stall: assert property (p_stall) else $error("early");
endmodule
bind mcl_guard mcl_checker #(
    .RATING_A(RATING_A),
    .TICK_CYCLES(TICK_CYCLES)
) u_mcl_chk (
    .i_sys_clk, .i_reset_n, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
    .o_hrdata, .o_hreadyout, .o_hresp, .i_motor_cur_a, .i_overtemp,
    .o_cur_cmd_a, .o_drive_en, .o_estop, .o_fault_code
);
`default_nettype wire

// ==== sim/mcl_bridge_model.sv ====
// Purpose: bridge and current sense stand-in
// Assumes: current follows demand up to the command
// Notes: no current flows while drive is disabled
`timescale 1ns/1ps
`default_nettype none
module mcl_bridge_model (
    input wire logic i_sys_clk,
    input wire logic [7:0] i_demand_a,
    input wire logic [7:0] i_cur_cmd_a,
    input wire logic i_drive_en,
    output logic [7:0] o_motor_cur_a
);
    initial o_motor_cur_a = 8'h00;
    // the bridge never pushes more than it is allowed
    always @(posedge i_sys_clk)
    begin
        if (!i_drive_en)
            o_motor_cur_a <= 8'h00;
        else if (i_demand_a < i_cur_cmd_a)
            o_motor_cur_a <= i_demand_a;
        else
            o_motor_cur_a <= i_cur_cmd_a;
    end
endmodule
`default_nettype wire

// ==== sim/mcl_guard_tb.sv ====
// Purpose: self-checking bench for mcl_guard
// Assumes: tick of 10 cycles, 40 A rating
// Notes: the bridge model closes the current loop
`timescale 1ns/1ps
`default_nettype none
module mcl_guard_tb;
    logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic ot = 1'b0, brk_on = 1'b0, brk_off = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdat;
    logic [7:0] dem = 8'h00, cur, cmd;
    logic [17:0] comp;
    logic [3:0] fcode;
    logic hready, hresp, den, estop, irq;
    int miscompares = 0;
    int cmp_count = 0;
    // 10 MHz clock
    always #50 clk = ~clk;
    mcl_guard #(.TICK_CYCLES(10)) dut (
        .i_sys_clk(clk), .i_reset_n(rst_n), .i_clk_en(1'b1),
        .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
        .o_hresp(hresp), .i_motor_cur_a(cur), .i_overtemp(ot),
        .i_brake_engage(brk_on), .i_brake_release(brk_off),
        .o_cur_cmd_a(cmd), .o_comp_mv(comp), .o_drive_en(den),
        .o_estop(estop), .o_fault_code(fcode), .o_irq(irq)
    );
    mcl_bridge_model bridge (
        .i_sys_clk(clk), .i_demand_a(dem), .i_cur_cmd_a(cmd),
        .i_drive_en(den), .o_motor_cur_a(cur)
    );
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one single-word transfer, address phase then data phase
    task automatic ahb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rdat = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask
    task automatic wait_cmd(input logic [7:0] v, output int n);
        n = 0;
        while (cmd !== v && n < 300)
        begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask
    // defaults, write clamps, rating clamp and thermal derate
    task automatic t_regs();
        rd(8'h04, 32'h3E8);
        rd(8'h08, 32'h32);
        rd(8'h0C, 32'h32);
        rd(8'h10, 32'h28);
        rd(8'h14, 32'h408);
        rd(8'h18, 32'h19);
        rd(8'h30, 32'h0);
        chk(cmd, 32'h30);
        ahb(1'b1, 8'h00, 32'h3FF);
        rd(8'h00, 32'h3FC);
        ahb(1'b1, 8'h08, 32'h64);
        rd(8'h08, 32'h3C);
        ahb(1'b1, 8'h10, 32'h50);
        repeat (6) @(posedge clk);
        chk(cmd, 32'h30);
        ahb(1'b1, 8'h10, 32'h1E);
        ot <= 1'b1;
        repeat (8) @(posedge clk);
        chk(cmd, 32'h14);
        ot <= 1'b0;
        repeat (8) @(posedge clk);
        chk(cmd, 32'h26);
        rd(8'h2C, 32'h26);
    endtask
    // damped compensation and seeding after a parked stop
    task automatic t_comp();
        ahb(1'b1, 8'h08, 32'h32);
        ahb(1'b1, 8'h00, 32'h190);
        ahb(1'b1, 8'h04, 32'hC8);
        dem <= 8'h14;
        repeat (8) @(posedge clk);
        chk(comp, 32'h7D0);
        ahb(1'b1, 8'h04, 32'h3E8);
        brk_on <= 1'b1;
        repeat (8) @(posedge clk);
        chk(comp, 32'hFA0);
        ahb(1'b0, 8'h1C, 32'h0);
        chk(rdat[15:8], 32'h14);
        brk_on <= 1'b0;
        brk_off <= 1'b1;
        dem <= 8'h05;
        repeat (8) @(posedge clk);
        chk(comp, 32'hFA0);
        ahb(1'b0, 8'h1C, 32'h0);
        chk(rdat[5], 32'h1);
        dem <= 8'h1E;
        brk_off <= 1'b0;
        repeat (8) @(posedge clk);
        chk(comp, 32'h1770);
        dem <= 8'h05;
        brk_off <= 1'b1;
        repeat (8) @(posedge clk);
        chk(comp, 32'h3E8);
        brk_off <= 1'b0;
        dem <= 8'h00;
    endtask
    // boost window, its interrupt and the re-arm delay
    task automatic t_boost();
        int n;
        ahb(1'b1, 8'h18, 32'h0);
        ahb(1'b1, 8'h24, 32'h7);
        ahb(1'b1, 8'h28, 32'h2);
        rd(8'h28, 32'h2);
        ahb(1'b1, 8'h14, 32'h108);
        dem <= 8'h23;
        wait_cmd(8'h1E, n);
        dem <= 8'h00;
        chk(n >= 85 && n <= 125, 32'h1);
        repeat (2) @(posedge clk);
        chk(irq, 32'h1);
        ahb(1'b1, 8'h28, 32'h0);
        repeat (2) @(posedge clk);
        chk(irq, 32'h0);
        rd(8'h20, 32'h2);
        ahb(1'b1, 8'h24, 32'h2);
        rd(8'h20, 32'h0);
        repeat (100) @(posedge clk);
        chk(cmd, 32'h1E);
        wait_cmd(8'h26, n);
        chk(cmd, 32'h26);
    endtask
    // stall timer off at zero, restart on a dip, latched fault
    task automatic t_stall();
        int n;
        ahb(1'b1, 8'h14, 32'h0);
        dem <= 8'hFF;
        repeat (300) @(posedge clk);
        chk(estop, 32'h0);
        dem <= 8'h00;
        ahb(1'b1, 8'h18, 32'h1);
        ahb(1'b1, 8'h28, 32'h1);
        dem <= 8'hFF;
        repeat (60) @(posedge clk);
        dem <= 8'h00;
        repeat (20) @(posedge clk);
        dem <= 8'hFF;
        repeat (60) @(posedge clk);
        chk(estop, 32'h0);
        n = 0;
        while (estop !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            n++;
        end
        repeat (2) @(posedge clk);
        chk({irq, den, fcode, cmd}, {18'h0, 2'h2, 4'h4, 8'h00});
        chk(estop, 32'h1);
        ahb(1'b1, 8'h18, 32'h0);
        dem <= 8'h00;
        brk_off <= 1'b1;
        repeat (20) @(posedge clk);
        chk({estop, den}, 32'h2);
        do_reset();
        chk({estop, den}, 32'h1);
    endtask
    task automatic finish_test();
        $display("compares %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // hang guard, far beyond the expected run length
    initial
    begin
        #3000000;
        miscompares++;
        finish_test();
    end
    initial
    begin
        do_reset();
        t_regs();
        t_comp();
        t_boost();
        t_stall();
        finish_test();
    end
endmodule
`default_nettype wire
